// ===== core/bie_params.svh
`ifndef BIE_PARAMS_SVH
`define BIE_PARAMS_SVH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define BIE_OFF_IW 12'h000
`define BIE_OFF_DW 12'h004
`define BIE_OFF_TL1 12'h008
`define BIE_OFF_TL2 12'h00c
`define BIE_OFF_SPC 12'h010
`define BIE_OFF_SST 12'h014
`define BIE_OFF_STAT 12'h018
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define BIE_RST_WORD 32'h00000000
// ---------------------------------------------
// field positions, bit 0 is the lsb here
// ---------------------------------------------
`define BIE_IW_XLAT 1
`define BIE_IW_ON 0
`define BIE_DW_XLAT 2
`define BIE_DW_STORE 1
`define BIE_DW_LOAD 0
`define BIE_TL_IRQ_ON 0
`define BIE_MSR_ILE 16
`define BIE_MSR_EE 15
`define BIE_MSR_IP 6
`define BIE_MSR_IR 5
`define BIE_MSR_DR 4
`define BIE_MSR_LE 0
// ---------------------------------------------
// masks and vector offsets
// ---------------------------------------------
`define BIE_SST_KEEP 32'h87c0ffff
`define BIE_MSR_KEEP 32'h00011040
`define BIE_VEC_TRACE 32'h00000d00
`define BIE_VEC_INSTR_WATCH_REG 32'h00001300
`define BIE_VEC_SMI 32'h00001400
`define BIE_VEC_THERM 32'h00001700
// ---------------------------------------------
// timing counts
// ---------------------------------------------
`define BIE_MISP_EXTRA 2'h2
`endif

// ===== core/bie_pkg.sv
// ---------------------------------------------
// types
// ---------------------------------------------
package bie_pkg;
	typedef enum logic [1:0] {A_IDLE, A_DRAIN, A_HALT} bie_drain_e;
	typedef enum logic [1:0] {C_SMI, C_DBG, C_THERM} bie_cause_e;
endpackage : bie_pkg

// ===== core/bie_sync2.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// two flop synchroniser
// ---------------------------------------------
module bie_sync2 #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : bie_sync2
`default_nettype wire

// ===== core/bie_exc_entry.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bie_params.svh"
// What this block does
// RL1: compare watch bits 0-29 with completing address
// RL2: fire needs translation match and enable
// RL3: matched instruction does not complete first unless its soft stop is already done
// RL4: report address matches to debug port
// RL5: breakpoint vectors to offset 0x01300
// RL6: saved pc gets next instruction address
// RL7: saved state copies selected bits, clears others
// RL8: entry clears control bits, copies byte order
// RL9: watch write ignored by next instruction
// RL10: management interrupt beats external, vector 0x01400
// RL11: requester holds management request until handler
// RL12: management request halts dispatch, drains pipeline
// RL13: thermal enabled per limit, masked, vector 0x01700
// RL14: thermal waits next completion and store drain
// RL15: data watch compares double-word, raises fault
// RL16: data watch translation, store, load enables
// RL17: soft stop replaces trace and breakpoint exceptions
// RL18: breakpoint beats trace in both cases
// RL19: debug stop request unmaskable, drains like interrupt
// RL20: one soft stop per matched instruction
// RL21: exceptions signalled one cycle after cause
// RL22: hard reset adds cycles on misprediction
// RL23: recoverable means queue empty, next completed
// RL24: redirect is selected base plus offset
module bie_exc_entry #(
	parameter logic [31:0] VEC_BASE_HIGH = 32'hfff00000,
	parameter logic [31:0] VEC_HARD_RESET = 32'h00000100,
	parameter logic [31:0] VEC_MACH_CHECK = 32'h00000200
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] machineState,
	input wire logic cmplValid,
	input wire logic [31:0] cmplPc,
	input wire logic cmplDone,
	input wire logic traceCond,
	input wire logic [31:0] nextPc,
	input wire logic pipeEmpty,
	input wire logic storeQueueEmpty,
	input wire logic otherExc,
	input wire logic lsuValid,
	input wire logic [31:0] lsuAddr,
	input wire logic lsuStore,
	input wire logic sysMgmtRequest,
	input wire logic thermalCross,
	input wire logic hardResetReq,
	input wire logic machineCheckReq,
	input wire logic specMispredict,
	input wire logic softStopEn,
	input wire logic softStopReq,
	output logic cmplBlock,
	output logic dispatchHalt,
	output logic completionHalt,
	output logic extIrqHold,
	output logic dsiWatch,
	output logic iaddrMatchReport,
	output logic softStop,
	output logic excTake,
	output logic [31:0] excVector,
	output logic [31:0] msrNew
);
	// ---------------------------------------------
	// declarations
	// ---------------------------------------------
	logic [31:0] instrWatch_q, instrWatchOld_q, dataWatch_q, tempLimitOne_q, tempLimitTwo_q;
	logic [31:0] savedPc_q, savedState_q, rdata_d;
	logic watchStale_q, stopDone_q, errResp_q;
	logic [1:0] hrCnt_q;
	logic smiSync, thermSync;
	bie_pkg::bie_drain_e aState_q;
	bie_pkg::bie_cause_e cause_q;
	logic [31:0] iwSel, vecBase, msrEntry;
	logic apbWr, apbSetup, addrHit, iaddrHit, bpFire, stopBlock, hardReq, hardTake;
	logic smiPend, dbgPend, thermPend, drainDone, asyncReady, asyncTake, dwHit, mapped, roAddr;

	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	bie_sync2 #(.W(2)) uSync (
		.mclk(mclk),
		.resetn(resetn),
		.din({sysMgmtRequest, thermalCross}),
		.dout({smiSync, thermSync})
	);

	// ---------------------------------------------
	// apb slave
	// ---------------------------------------------
	assign apbWr = psel & penable & pwrite;
	assign apbSetup = psel & ~penable;
	assign pready = 1'b1;
	always_comb begin
		mapped = 1'b1;
		roAddr = 1'b0;
		rdata_d = 32'h00000000;
		case (paddr)
			`BIE_OFF_IW: rdata_d = instrWatch_q;
			`BIE_OFF_DW: rdata_d = dataWatch_q;
			`BIE_OFF_TL1: rdata_d = tempLimitOne_q;
			`BIE_OFF_TL2: rdata_d = tempLimitTwo_q;
			`BIE_OFF_SPC: begin
				rdata_d = savedPc_q;
				roAddr = 1'b1;
			end
			`BIE_OFF_SST: begin
				rdata_d = savedState_q;
				roAddr = 1'b1;
			end
			`BIE_OFF_STAT: begin
				rdata_d = {24'h000000, aState_q, cause_q, stopDone_q, watchStale_q, smiSync, thermSync};
				roAddr = 1'b1;
			end
			default: mapped = 1'b0;
		endcase
	end

	// read data and error are caught in setup so the access phase needs no wait
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata <= `BIE_RST_WORD;
			errResp_q <= 1'b0;
		end else if (apbSetup) begin
			prdata <= pwrite ? `BIE_RST_WORD : rdata_d;
			errResp_q <= ~mapped | (pwrite & roAddr);
		end
	end
	assign pslverr = psel & penable & errResp_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			instrWatch_q <= `BIE_RST_WORD;
			dataWatch_q <= `BIE_RST_WORD;
			tempLimitOne_q <= `BIE_RST_WORD;
			tempLimitTwo_q <= `BIE_RST_WORD;
		end else if (apbWr & ~errResp_q) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b]) begin
					case (paddr)
						`BIE_OFF_IW: instrWatch_q[b*8 +: 8] <= pwdata[b*8 +: 8];
						`BIE_OFF_DW: dataWatch_q[b*8 +: 8] <= pwdata[b*8 +: 8];
						`BIE_OFF_TL1: tempLimitOne_q[b*8 +: 8] <= pwdata[b*8 +: 8];
						`BIE_OFF_TL2: tempLimitTwo_q[b*8 +: 8] <= pwdata[b*8 +: 8];
						default: ;
					endcase
				end
			end
		end
	end

	// the first completion after a watch write still sees the old watch value
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			instrWatchOld_q <= `BIE_RST_WORD;
			watchStale_q <= 1'b0;
		end else if (apbWr & ~errResp_q & (paddr == `BIE_OFF_IW)) begin
			instrWatchOld_q <= watchStale_q ? instrWatchOld_q : instrWatch_q; // RL9
			watchStale_q <= 1'b1; // RL9
		end else if (cmplDone) begin
			watchStale_q <= 1'b0;
		end
	end

	// ---------------------------------------------
	// instruction and data watch
	// ---------------------------------------------
	assign iwSel = watchStale_q ? instrWatchOld_q : instrWatch_q; // RL9
	assign addrHit = cmplValid & (cmplPc[31:2] == iwSel[31:2]); // RL1
	assign iaddrHit = addrHit & (iwSel[`BIE_IW_XLAT] == machineState[`BIE_MSR_IR]) & iwSel[`BIE_IW_ON]; // RL2
	assign stopBlock = softStopEn & stopDone_q; // RL20
	assign bpFire = iaddrHit & ~stopBlock;
	assign cmplBlock = bpFire; // RL3
	assign dwHit = lsuValid & (lsuAddr[31:3] == dataWatch_q[31:3]) // RL15
		& (dataWatch_q[`BIE_DW_XLAT] == machineState[`BIE_MSR_DR]) // RL16
		& ((lsuStore & dataWatch_q[`BIE_DW_STORE]) | (~lsuStore & dataWatch_q[`BIE_DW_LOAD])); // RL16

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dsiWatch <= 1'b0;
			iaddrMatchReport <= 1'b0;
		end else begin
			dsiWatch <= dwHit; // RL15
			iaddrMatchReport <= addrHit; // RL4
		end
	end

	// ---------------------------------------------
	// hard reset and machine check
	// ---------------------------------------------
	assign hardReq = hardResetReq | machineCheckReq;
	assign hardTake = hardReq & (~specMispredict | (hrCnt_q == `BIE_MISP_EXTRA)); // RL22
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hrCnt_q <= 2'h0;
		end else if (~hardReq | hardTake) begin
			hrCnt_q <= 2'h0;
		end else if (specMispredict) begin
			hrCnt_q <= hrCnt_q + 2'h1; // RL22
		end
	end

	// ---------------------------------------------
	// asynchronous drain sequencer
	// ---------------------------------------------
	// entry cycle still shows the old mask and a held request, so no fresh drain starts then
	assign smiPend = smiSync & machineState[`BIE_MSR_EE] & ~excTake;
	assign dbgPend = softStopReq & ~softStop; // RL19
	assign thermPend = thermSync & machineState[`BIE_MSR_EE] & ~excTake // RL13
		& (tempLimitOne_q[`BIE_TL_IRQ_ON] | tempLimitTwo_q[`BIE_TL_IRQ_ON]); // RL13
	assign extIrqHold = smiSync; // RL10
	assign drainDone = (cause_q == bie_pkg::C_SMI) ? pipeEmpty : (cmplDone | ~cmplValid); // RL12 RL14
	assign asyncReady = (aState_q == bie_pkg::A_HALT) & storeQueueEmpty & ~otherExc // RL23
		& ((cause_q != bie_pkg::C_SMI) | pipeEmpty);
	assign asyncTake = asyncReady & ~hardTake & ~bpFire & ~traceCond;
	assign dispatchHalt = (aState_q != bie_pkg::A_IDLE); // RL12
	assign completionHalt = (aState_q == bie_pkg::A_HALT); // RL14

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			aState_q <= bie_pkg::A_IDLE;
			cause_q <= bie_pkg::C_SMI;
		end else begin
			case (aState_q)
				bie_pkg::A_IDLE: begin
					if (smiPend | dbgPend | thermPend) begin
						aState_q <= bie_pkg::A_DRAIN;
						cause_q <= smiPend ? bie_pkg::C_SMI : (dbgPend ? bie_pkg::C_DBG : bie_pkg::C_THERM);
					end
				end
				bie_pkg::A_DRAIN: begin
					// an exception raised while draining goes first, request stays pending
					if (otherExc) begin
						aState_q <= bie_pkg::A_IDLE; // RL14
					end else if (drainDone) begin
						aState_q <= bie_pkg::A_HALT; // RL12
					end
				end
				bie_pkg::A_HALT: begin
					if (otherExc | asyncTake) begin
						aState_q <= bie_pkg::A_IDLE;
					end
				end
				default: aState_q <= bie_pkg::A_IDLE;
			endcase
		end
	end

	// ---------------------------------------------
	// exception entry
	// ---------------------------------------------
	assign vecBase = machineState[`BIE_MSR_IP] ? VEC_BASE_HIGH : 32'h00000000;
	always_comb begin
		msrEntry = machineState & `BIE_MSR_KEEP; // RL8
		msrEntry[`BIE_MSR_LE] = machineState[`BIE_MSR_ILE]; // RL8
	end

	// one source wins per cycle: hard, breakpoint, trace, then drained requests
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			excTake <= 1'b0;
			softStop <= 1'b0;
			excVector <= `BIE_RST_WORD;
			msrNew <= `BIE_RST_WORD;
			savedPc_q <= `BIE_RST_WORD;
			savedState_q <= `BIE_RST_WORD;
		end else begin
			excTake <= 1'b0;
			softStop <= 1'b0;
			if (hardTake) begin
				excTake <= 1'b1; // RL21
				excVector <= vecBase | (hardResetReq ? VEC_HARD_RESET : VEC_MACH_CHECK);
				savedPc_q <= nextPc;
			end else if (bpFire & softStopEn) begin
				softStop <= 1'b1; // RL17 RL18
			end else if (bpFire) begin
				excTake <= 1'b1; // RL3 RL21
				excVector <= vecBase | `BIE_VEC_INSTR_WATCH_REG; // RL5 RL24
				savedPc_q <= cmplPc; // RL6
			end else if (traceCond & softStopEn & ~stopBlock) begin
				softStop <= 1'b1; // RL17
			end else if (traceCond & ~softStopEn) begin
				excTake <= 1'b1;
				excVector <= vecBase | `BIE_VEC_TRACE; // RL24
				savedPc_q <= nextPc; // RL6
			end else if (asyncTake & (cause_q == bie_pkg::C_DBG)) begin
				softStop <= 1'b1; // RL19
			end else if (asyncTake) begin
				excTake <= 1'b1;
				excVector <= vecBase | ((cause_q == bie_pkg::C_SMI) ? `BIE_VEC_SMI : `BIE_VEC_THERM); // RL10 RL13
				savedPc_q <= nextPc; // RL6
			end
			if (hardTake | (bpFire & ~softStopEn) | (~hardTake & ~bpFire & ((traceCond & ~softStopEn)
				| (asyncTake & (cause_q != bie_pkg::C_DBG))))) begin
				savedState_q <= machineState & `BIE_SST_KEEP; // RL7
				msrNew <= msrEntry; // RL8
			end
		end
	end

	// set wins over the clearing completion
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stopDone_q <= 1'b0;
		end else if (softStopEn & ~hardTake & (bpFire | (traceCond & ~stopBlock)
			| (asyncTake & (cause_q == bie_pkg::C_DBG)))) begin
			stopDone_q <= 1'b1; // RL20
		end else if (cmplDone) begin
			stopDone_q <= 1'b0; // RL20
		end
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_instr_watch_reg_vector: assert property (bpFire && !softStopEn && !hardTake |=> excTake && excVector == ($past(vecBase) | 32'h00001300) && savedPc_q == $past(cmplPc)) else $error("breakpoint entry wrong"); // RL5
	a_instr_watch_reg_enable: assert property (cmplValid && !iwSel[`BIE_IW_ON] |-> !cmplBlock) else $error("breakpoint without enable"); // RL2
	a_instr_watch_reg_xlat: assert property (addrHit && iwSel[`BIE_IW_XLAT] != machineState[`BIE_MSR_IR] |-> !cmplBlock) else $error("breakpoint xlat mismatch"); // RL2
	a_sst_bits: assert property (excTake |-> (savedState_q & 32'h783f0000) == 32'h00000000 && savedState_q == ($past(machineState) & 32'h87c0ffff)) else $error("saved state wrong"); // RL7
	a_msr_entry: assert property (excTake |-> msrNew[`BIE_MSR_LE] == $past(machineState[`BIE_MSR_ILE]) && !msrNew[`BIE_MSR_EE] && !msrNew[`BIE_MSR_IR]) else $error("entry state wrong"); // RL8
	a_smi_vector: assert property (asyncTake && cause_q == bie_pkg::C_SMI |=> excTake && excVector[19:0] == 20'h01400) else $error("smi vector wrong"); // RL10
	a_smi_halt: assert property (aState_q == bie_pkg::A_IDLE && smiPend |=> dispatchHalt [*2]) else $error("dispatch not halted"); // RL12
	a_therm_mask: assert property (aState_q == bie_pkg::A_IDLE && !smiPend && !dbgPend && !machineState[`BIE_MSR_EE] |=> aState_q == bie_pkg::A_IDLE) else $error("thermal not masked"); // RL13
	a_dw_fault: assert property (dsiWatch |-> $past(lsuAddr[31:3]) == $past(dataWatch_q[31:3]) && $past(lsuValid)) else $error("data watch wrong"); // RL15
	a_one_stop: assert property (softStopEn && stopDone_q && iaddrHit |-> !cmplBlock ##1 !softStop) else $error("second soft stop"); // RL20
	a_bp_over_trace: assert property (bpFire && traceCond && !hardTake && !softStopEn |=> excVector[19:0] == 20'h01300) else $error("trace beat breakpoint"); // RL18
	a_hard_latency: assert property (hardReq && !specMispredict |=> excTake) else $error("hard latency wrong"); // RL21
	a_hard_misp: assert property (hardReq && specMispredict && hrCnt_q == 2'h0 ##1 hardReq && specMispredict |-> !excTake ##1 (hardReq && specMispredict) [*1] ##1 excTake) else $error("mispredict delay wrong"); // RL22

	c_instr_watch_reg_exc: cover property (bpFire && !softStopEn ##1 excTake);
	c_smi_taken: cover property (aState_q == bie_pkg::A_HALT && cause_q == bie_pkg::C_SMI ##1 excTake);
	c_dbg_stop: cover property (asyncTake && cause_q == bie_pkg::C_DBG ##1 softStop);
	c_dw_hit: cover property (dsiWatch);
endmodule : bie_exc_entry
`default_nettype wire

// ===== dv/bie_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// pipeline, debug port and interrupt source model
// ---------------------------------------------
module bie_pipe_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic issue,
	input wire logic [31:0] issuePc,
	input wire logic [1:0] issueSlow,
	input wire logic smiGo,
	input wire logic stopGo,
	input wire logic sqBusy,
	input wire logic excTake,
	input wire logic softStop,
	input wire logic cmplBlock,
	input wire logic completionHalt,
	output logic cmplValid,
	output logic [31:0] cmplPc,
	output logic cmplDone,
	output logic [31:0] nextPc,
	output logic pipeEmpty,
	output logic storeQueueEmpty,
	output logic sysMgmtRequest,
	output logic softStopReq
);
	logic validQ;
	logic [1:0] waitQ;
	// flush seen in the take cycle itself, else a held match takes twice
	assign cmplValid = validQ & ~excTake & ~softStop;
	assign pipeEmpty = ~validQ;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			validQ <= 1'h0;
			waitQ <= 2'h0;
			cmplPc <= 32'h0;
			cmplDone <= 1'h0;
			nextPc <= 32'h0;
		end else begin
			cmplDone <= 1'h0;
			if (issue) begin
				validQ <= 1'h1;
				cmplPc <= issuePc;
				nextPc <= issuePc;
				waitQ <= issueSlow;
			end else if (validQ && !cmplValid) begin
				validQ <= 1'h0;
				cmplPc <= ~cmplPc;
			end else if (validQ && !cmplBlock && !completionHalt) begin
				if (waitQ != 2'h0) begin
					waitQ <= waitQ - 2'h1;
				end else begin
					cmplDone <= 1'h1;
					validQ <= 1'h0;
					nextPc <= cmplPc + 32'h4;
					// released address is scrambled, never left stale
					cmplPc <= ~cmplPc;
				end
			end
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sysMgmtRequest <= 1'h0;
			softStopReq <= 1'h0;
			storeQueueEmpty <= 1'h1;
		end else begin
			storeQueueEmpty <= ~sqBusy;
			if (smiGo) sysMgmtRequest <= 1'h1;
			else if (excTake) sysMgmtRequest <= 1'h0;
			if (stopGo) softStopReq <= 1'h1;
			else if (softStop) softStopReq <= 1'h0;
		end
	end
endmodule : bie_pipe_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, machineState, cmplPc, nextPc, lsuAddr, excVector, msrNew, issuePc;
	logic [3:0] pstrb;
	logic cmplValid, cmplDone, traceCond, pipeEmpty, storeQueueEmpty, otherExc, lsuValid, lsuStore;
	logic sysMgmtRequest, thermalCross, hardResetReq, machineCheckReq, specMispredict, softStopEn, softStopReq;
	logic cmplBlock, dispatchHalt, completionHalt, extIrqHold, dsiWatch, iaddrMatchReport, softStop, excTake;
	logic issue, smiGo, stopGo, sqBusy;
	logic [1:0] issueSlow;
	logic [6:0] seen;
	int errCount, checksDone, n;
	localparam logic [6:0] E_TAKE = 7'h01, E_STOP = 7'h02, E_DSI = 7'h04, E_HALT = 7'h08;
	localparam logic [6:0] E_BLK = 7'h10, E_RPT = 7'h20, E_DONE = 7'h40;
	bie_exc_entry i_dut (.*);
	bie_pipe_model i_pipe (.*);
	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end
	// the core loads the new machine state on entry
	always @(posedge mclk) if (excTake === 1'h1) machineState <= msrNew;
	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		chk("pready", 32'h1, {31'h0, pready});
		if (!wr) chk("prdata", d, prdata);
		chk("pslverr", {31'h0, e}, {31'h0, pslverr});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// samples at the edge, so each bit is the level of the cycle just ended
	task waitEv(input logic [6:0] want, input int maxc);
		logic [6:0] now;
		seen = 7'h0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			now = {cmplDone, iaddrMatchReport, cmplBlock, dispatchHalt, dsiWatch, softStop, excTake};
			seen |= now;
		end while ((now & want) == 7'h0 && n < maxc);
		if ((now & want) == 7'h0) n = -1;
	endtask : waitEv
	task pulse(input logic [31:0] pc, input logic [1:0] slow, input logic sys_mgmt_request, input logic stp);
		@(posedge mclk);
		issue <= ~sys_mgmt_request & ~stp;
		issuePc <= pc;
		issueSlow <= slow;
		smiGo <= sys_mgmt_request;
		stopGo <= stp;
		@(posedge mclk);
		issue <= 1'h0;
		smiGo <= 1'h0;
		stopGo <= 1'h0;
	endtask : pulse
	task ev(input logic [6:0] want, input int maxc, input logic [6:0] mask, input logic [6:0] exp);
		waitEv(want, maxc);
		chk("events", {25'h0, exp}, {25'h0, seen & mask});
	endtask : ev
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task t_regs;
		apb(1'h0, 12'h000, 32'h0, 1'h0);
		apb(1'h1, 12'h004, 32'h12345678, 1'h0);
		apb(1'h0, 12'h004, 32'h12345678, 1'h0);
		apb(1'h1, 12'h010, 32'h1, 1'h1);
		apb(1'h0, 12'h010, 32'h0, 1'h0);
		apb(1'h0, 12'h01c, 32'h0, 1'h1);
		$display("test regs done");
	endtask : t_regs
	task t_ibreak;
		machineState <= 32'h0001ffff;
		apb(1'h1, 12'h000, 32'h00001003, 1'h0);
		pulse(32'h1000, 2'h0, 1'h0, 1'h0);
		ev(E_DONE, 10, E_TAKE | E_BLK | E_RPT | E_DONE, E_DONE);
		pulse(32'h1000, 2'h0, 1'h0, 1'h0);
		ev(E_TAKE, 10, E_TAKE | E_BLK | E_RPT | E_DONE, E_TAKE | E_BLK | E_RPT);
		chk("excVector", 32'hfff01300, excVector);
		chk("msrNew", 32'h00011041, msrNew);
		apb(1'h0, 12'h010, 32'h00001000, 1'h0);
		apb(1'h0, 12'h014, 32'h0000ffff, 1'h0);
		machineState <= 32'h0001ffdf;
		pulse(32'h1000, 2'h0, 1'h0, 1'h0);
		ev(E_DONE, 10, E_TAKE | E_RPT | E_DONE, E_RPT | E_DONE);
		$display("test ibreak done");
	endtask : t_ibreak
	task t_dwatch;
		logic [31:0] addr [3];
		logic [2:0] st, hit;
		addr = '{32'h2004, 32'h2004, 32'h2008};
		st = 3'h6;
		hit = 3'h2;
		machineState <= 32'h0001ffff;
		apb(1'h1, 12'h004, 32'h00002006, 1'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			lsuValid <= 1'h1;
			lsuAddr <= addr[i];
			lsuStore <= st[i];
			@(posedge mclk);
			lsuValid <= 1'h0;
			ev(E_DSI, 3, E_DSI, hit[i] ? E_DSI : 7'h0);
		end
		$display("test dwatch done");
	endtask : t_dwatch
	task t_smi;
		@(posedge mclk);
		machineState <= 32'h0001ffff;
		pulse(32'h3000, 2'h2, 1'h0, 1'h0);
		pulse(32'h0, 2'h0, 1'h1, 1'h0);
		ev(E_TAKE, 30, E_TAKE | E_HALT | E_DONE, E_TAKE | E_HALT | E_DONE);
		chk("excVector", 32'hfff01400, excVector);
		chk("extIrqHold", 32'h1, {31'h0, extIrqHold});
		$display("test smi done");
	endtask : t_smi
	task t_therm;
		@(posedge mclk);
		machineState <= 32'h00017fff;
		apb(1'h1, 12'h00c, 32'h1, 1'h0);
		thermalCross <= 1'h1;
		ev(E_TAKE, 12, E_TAKE, 7'h0);
		machineState <= 32'h0001ffff;
		sqBusy <= 1'h1;
		ev(E_TAKE, 12, E_TAKE, 7'h0);
		sqBusy <= 1'h0;
		ev(E_TAKE, 12, E_TAKE, E_TAKE);
		chk("excVector", 32'hfff01700, excVector);
		thermalCross <= 1'h0;
		$display("test therm done");
	endtask : t_therm
	task t_soft;
		@(posedge mclk);
		machineState <= 32'h00017fff;
		softStopEn <= 1'h1;
		pulse(32'h1000, 2'h0, 1'h0, 1'h0);
		ev(E_STOP, 10, E_STOP | E_TAKE, E_STOP);
		pulse(32'h1000, 2'h0, 1'h0, 1'h0);
		ev(E_DONE, 10, E_STOP | E_TAKE | E_DONE, E_DONE);
		pulse(32'h0, 2'h0, 1'h0, 1'h1);
		ev(E_STOP, 12, E_STOP | E_TAKE, E_STOP);
		softStopEn <= 1'h0;
		$display("test soft done");
	endtask : t_soft
	task t_hard;
		for (int m = 0; m < 2; m++) begin
			@(posedge mclk);
			hardResetReq <= ~m[0];
			machineCheckReq <= m[0];
			specMispredict <= m[0];
			waitEv(E_TAKE, 8);
			chk("latency", m ? 32'h4 : 32'h2, n);
			chk("excVector", m ? 32'hfff00200 : 32'hfff00100, excVector);
			hardResetReq <= 1'h0;
			machineCheckReq <= 1'h0;
			specMispredict <= 1'h0;
			repeat (3) @(posedge mclk);
		end
		$display("test hard done");
	endtask : t_hard
	task t_trace;
		machineState <= 32'h0001ffff;
		pulse(32'h1000, 2'h0, 1'h0, 1'h0);
		traceCond <= 1'h1;
		@(posedge mclk);
		traceCond <= 1'h0;
		ev(E_TAKE, 10, E_TAKE | E_STOP, E_TAKE);
		chk("excVector", 32'hfff01300, excVector);
		$display("test trace done");
	endtask : t_trace
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// ---------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------
	initial begin
		{resetn, psel, penable, pwrite, traceCond, otherExc, lsuValid, lsuStore} = 8'h0;
		{thermalCross, hardResetReq, machineCheckReq, specMispredict, softStopEn} = 5'h0;
		{issue, smiGo, stopGo, sqBusy, issueSlow} = 6'h0;
		{paddr, pwdata, lsuAddr, issuePc, machineState} = '0;
		pstrb = 4'hf;
		errCount = 0;
		checksDone = 0;
		repeat (8) @(posedge mclk);
		resetn <= 1'h1;
		t_regs();
		t_ibreak();
		t_dwatch();
		t_smi();
		t_therm();
		t_soft();
		t_hard();
		t_trace();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		errCount++;
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
